// ---- src/sbsw_bank.v ----
// status and control word bank of a two-port serial board, apb slave
// Notes on behaviour
// RULE1: in terminal polling mode bits 0 to 7 of each counter word flag terminals 0 to 7 in use.
// RULE2: in sequence mode the low byte of each counter word holds the repeat count 00 to FF.
// RULE3: in no-protocol mode each counter word holds a four-digit decimal reception count.
// RULE4: a 4-bit sequence error code per port sits in bits 8-11 (port 1) and 12-15 (port 2).
// RULE5: bit 15 of a reception report is 1 when that port's error code holds data, else 0.
// RULE6: in sequence mode reception reports give case in bits 0-3, step in 4-7, 8-14 zero.
// RULE7: control bits 6 and 7 disable echoback per port for modem control in sequence mode.
// RULE8: control bits 0 and 1 restart port 1 and port 2 in every mode.
// RULE9: control bits 8 and 12 show a port's sequence executing in no-protocol or sequence mode.
// RULE10: trace word bits 6 and 7 show echoback disabled per port in sequence mode.
// RULE11: communication error codes are 0 normal to 7 command error, one per port.
// RULE12: software treats request bits as requests and other fields as read-only status.
`timescale 1ns/10ps
`include "sbsw_regs.vh"
module sbsw_bank (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] p1_terminal_active,
  input wire [7:0] p2_terminal_active,
  input wire [1:0] rx_byte,
  input wire [1:0] seq_start,
  input wire [1:0] seq_done,
  input wire [1:0] repeat_inc,
  input wire [1:0] err_valid,
  input wire [3:0] p1_err_code,
  input wire [3:0] p2_err_code,
  input wire [1:0] case_valid,
  input wire [3:0] p1_case_num,
  input wire [3:0] p2_case_num,
  input wire [3:0] p1_step_num,
  input wire [3:0] p2_step_num,
  input wire [1:0] trace_active,
  input wire [1:0] step_error,
  input wire [1:0] seq_end,
  input wire [1:0] abort_done,
  input wire [1:0] comm_err_valid,
  input wire [2:0] p1_comm_code,
  input wire [2:0] p2_comm_code,
  output reg [1:0] port_restart,
  output reg [1:0] cont_trace_req,
  output reg [1:0] shot_trace_req,
  output reg [1:0] echo_disable,
  output reg [1:0] abort_req,
  output reg [3:0] p1_comm_err,
  output reg [3:0] p2_comm_err,
  output reg irq
);
  reg [1:0] mode_reg;
  reg [15:0] ctrl_reg;
  reg [1:0] echo_stat_reg;
  reg [1:0] steperr_reg;
  reg [1:0] seqend_reg;
  reg [`SBSW_IRQ_W-1:0] irq_stat_reg;
  reg [`SBSW_IRQ_W-1:0] irq_mask_reg;
  reg [`SBSW_IRQ_W-1:0] irq_stat_next;
  reg [3:0] rst_cnt_reg;
  reg [15:0] rd_word;
  reg rd_hit;
  wire [15:0] cnt_word [0:1];
  wire [3:0] err_code [0:1];
  wire [1:0] stored;
  wire [7:0] rx_byte_word [0:1];
  wire [1:0] exec;
  wire [7:0] term [0:1];
  wire [3:0] err_in [0:1];
  wire [3:0] case_in [0:1];
  wire [3:0] step_in [0:1];
  wire [9:0] word_idx;
  wire wr_en;
  wire [`SBSW_IRQ_W-1:0] irq_events;
  wire pseq;
  wire [15:0] cnt_out [0:1];
  wire [31:0] restart_cyc;

  assign word_idx = paddr[11:2];
  assign wr_en = psel && penable && pwrite;
  assign pseq = (mode_reg == `SBSW_MODE_PSEQ);
  // restart length is reckoned at full width, then cut to the counter
  assign restart_cyc = `SBSW_RESTART_CYC;
  assign term[0] = p1_terminal_active;
  assign term[1] = p2_terminal_active;
  assign err_in[0] = p1_err_code;
  assign err_in[1] = p2_err_code;
  assign case_in[0] = p1_case_num;
  assign case_in[1] = p2_case_num;
  assign step_in[0] = p1_step_num;
  assign step_in[1] = p2_step_num;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_port
      sbsw_port u_port (
        .pclk(pclk),
        .presetn(presetn),
        .restart(port_restart[g]),
        .mode(mode_reg),
        .rx_byte(rx_byte[g]),
        .seq_start(seq_start[g]),
        .seq_done(seq_done[g]),
        .repeat_inc(repeat_inc[g]),
        .err_valid(err_valid[g]),
        .err_code(err_in[g]),
        .case_valid(case_valid[g]),
        .case_num(case_in[g]),
        .step_num(step_in[g]),
        .count_word(cnt_word[g]),
        .err_reg(err_code[g]),
        .stored_reg(stored[g]),
        .rx_reg(rx_byte_word[g]),
        .exec_reg(exec[g])
      );
      assign cnt_out[g] = (mode_reg == `SBSW_MODE_POLL) ? {8'h00, term[g]} : // see RULE1
                          cnt_word[g];
    end
  endgenerate

  // events: sequence end, step error, sequence error, per port
  assign irq_events = {err_valid, step_error, seq_end};

  always @* begin
    rd_hit = 1'b1;
    case (word_idx[7:0])
      `SBSW_IDX_P1_CNT: rd_word = cnt_out[0];
      `SBSW_IDX_P2_CNT: rd_word = cnt_out[1];
      `SBSW_IDX_TRACE: rd_word = {err_code[1], err_code[0], echo_stat_reg, 4'h0,
                                  trace_active}; // see RULE4 see RULE10
      `SBSW_IDX_P1_RX: rd_word = {stored[0], 7'h00, rx_byte_word[0]}; // see RULE5 see RULE6
      `SBSW_IDX_P2_RX: rd_word = {stored[1], 7'h00, rx_byte_word[1]}; // see RULE5 see RULE6
      `SBSW_IDX_CTRL: rd_word = {abort_req[1], seqend_reg[1], steperr_reg[1], exec[1],
                                 abort_req[0], seqend_reg[0], steperr_reg[0], exec[0],
                                 ctrl_reg[7:0]}; // see RULE9
      `SBSW_IDX_MODE: rd_word = {14'h0000, mode_reg};
      `SBSW_IDX_IRQ_STAT: rd_word = {10'h000, irq_stat_reg};
      `SBSW_IDX_IRQ_MASK: rd_word = {10'h000, irq_mask_reg};
      default: begin
        rd_word = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
    if (word_idx[9:8] != 2'h0) begin
      rd_hit = 1'b0;
    end
  end

  // set wins over a write-one clear in the same cycle
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_en && word_idx == {2'h0, `SBSW_IDX_IRQ_STAT}) begin
      irq_stat_next = irq_stat_reg & ~pwdata[`SBSW_IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | irq_events;
  end

  // apb: zero wait states; unmapped addresses answer with pslverr
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      // refused reads return zero even when the low index bits alias a register
      prdata <= (psel && !penable && !pwrite && rd_hit) ? {16'h0000, rd_word} : 32'h00000000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `SBSW_MODE_NOPROT;
      ctrl_reg <= 16'h0000;
      irq_mask_reg <= {`SBSW_IRQ_W{1'b0}};
      irq_stat_reg <= {`SBSW_IRQ_W{1'b0}};
      rst_cnt_reg <= 4'h0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_en && word_idx == {2'h0, `SBSW_IDX_CTRL}) begin
        // status bits of the word are not writable by software
        ctrl_reg <= pwdata[15:0] & `SBSW_CTRL_WMASK; // see RULE12
      end else begin
        // restart request self-clears when the restart count reaches 1, a cycle before the pulse drops; see RULE8
        if (rst_cnt_reg == 4'h1) begin
          ctrl_reg[`SBSW_CTRL_RESTART +: 2] <= 2'b00;
        end
        if (abort_done[0]) begin
          ctrl_reg[`SBSW_CTRL_P1_ABORT] <= 1'b0;
        end
        if (abort_done[1]) begin
          ctrl_reg[`SBSW_CTRL_P2_ABORT] <= 1'b0;
        end
      end
      if (wr_en && word_idx == {2'h0, `SBSW_IDX_CTRL} && pwdata[1:0] != 2'b00) begin
        rst_cnt_reg <= restart_cyc[3:0]; // see RULE8
      end else if (rst_cnt_reg != 4'h0) begin
        rst_cnt_reg <= rst_cnt_reg - 4'h1;
      end
      if (wr_en && word_idx == {2'h0, `SBSW_IDX_MODE}) begin
        mode_reg <= pwdata[1:0];
      end
      if (wr_en && word_idx == {2'h0, `SBSW_IDX_IRQ_MASK}) begin
        irq_mask_reg <= pwdata[`SBSW_IRQ_W-1:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_restart <= 2'b00;
      cont_trace_req <= 2'b00;
      shot_trace_req <= 2'b00;
      echo_disable <= 2'b00;
      echo_stat_reg <= 2'b00;
      abort_req <= 2'b00;
      steperr_reg <= 2'b00;
      seqend_reg <= 2'b00;
      p1_comm_err <= 4'h0;
      p2_comm_err <= 4'h0;
      irq <= 1'b0;
    end else begin
      port_restart <= ctrl_reg[`SBSW_CTRL_RESTART +: 2]; // see RULE8
      cont_trace_req <= pseq ? ctrl_reg[`SBSW_CTRL_CTRACE +: 2] : 2'b00;
      shot_trace_req <= pseq ? ctrl_reg[`SBSW_CTRL_STRACE +: 2] : 2'b00;
      // echoback only acts for modem control in sequence mode
      echo_disable <= pseq ? ctrl_reg[`SBSW_CTRL_ECHO +: 2] : 2'b00; // see RULE7
      echo_stat_reg <= pseq ? ctrl_reg[`SBSW_CTRL_ECHO +: 2] : 2'b00; // see RULE10
      abort_req <= pseq ? {ctrl_reg[`SBSW_CTRL_P2_ABORT], ctrl_reg[`SBSW_CTRL_P1_ABORT]} :
                   2'b00;
      steperr_reg <= pseq ? step_error | (steperr_reg & ~seq_start) : 2'b00;
      seqend_reg <= pseq ? seq_end | (seqend_reg & ~seq_start) : 2'b00;
      if (port_restart[0]) begin
        p1_comm_err <= 4'h0;
      end else if (comm_err_valid[0]) begin
        p1_comm_err <= {1'b0, p1_comm_code}; // see RULE11
      end
      if (port_restart[1]) begin
        p2_comm_err <= 4'h0;
      end else if (comm_err_valid[1]) begin
        p2_comm_err <= {1'b0, p2_comm_code}; // see RULE11
      end
      irq <= |(irq_stat_next & irq_mask_reg);
    end
  end
endmodule // sbsw_bank

// ---- src/sbsw_bcd_counter.v ----
// four-digit decimal reception counter for one port
`timescale 1ns/10ps
module sbsw_bcd_counter #(
  parameter DIGITS = 4
) (
  input wire pclk,
  input wire presetn,
  input wire clear,
  input wire inc,
  output reg [4*DIGITS-1:0] count_reg
);
  reg [4*DIGITS-1:0] count_next;
  reg carry;
  integer i;
  always @* begin
    count_next = count_reg;
    carry = inc;
    for (i = 0; i < DIGITS; i = i + 1) begin
      if (carry) begin
        if (count_reg[4*i +: 4] == 4'h9) begin
          count_next[4*i +: 4] = 4'h0;
        end else begin
          count_next[4*i +: 4] = count_reg[4*i +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
  end
  // rolls over 9999 to 0000, as a decimal display would
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {4*DIGITS{1'b0}};
    end else if (clear) begin
      count_reg <= {4*DIGITS{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end
endmodule // sbsw_bcd_counter

// ---- src/sbsw_port.v ----
// per-port sequence status: repeat count, error code, reception case and step
`timescale 1ns/10ps
`include "sbsw_regs.vh"
module sbsw_port (
  input wire pclk,
  input wire presetn,
  input wire restart,
  input wire [1:0] mode,
  input wire rx_byte,
  input wire seq_start,
  input wire seq_done,
  input wire repeat_inc,
  input wire err_valid,
  input wire [3:0] err_code,
  input wire case_valid,
  input wire [3:0] case_num,
  input wire [3:0] step_num,
  output wire [15:0] count_word,
  output reg [3:0] err_reg,
  output reg stored_reg,
  output reg [7:0] rx_reg,
  output reg exec_reg
);
  reg [7:0] rep_reg;
  wire [15:0] bcd_count;
  wire pseq;
  assign pseq = (mode == `SBSW_MODE_PSEQ);
  sbsw_bcd_counter #(.DIGITS(4)) u_bcd (
    .pclk(pclk),
    .presetn(presetn),
    .clear(restart),
    .inc(rx_byte && (mode == `SBSW_MODE_NOPROT)),
    .count_reg(bcd_count)
  );
  // counter word source depends on mode; terminal flags are merged by the top
  assign count_word = pseq ? {8'h00, rep_reg} : bcd_count; // see RULE2 see RULE3
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_reg <= 8'h00;
      err_reg <= `SBSW_ERR_NONE;
      stored_reg <= 1'b0;
      rx_reg <= 8'h00;
      exec_reg <= 1'b0;
    end else if (restart) begin
      rep_reg <= 8'h00;
      err_reg <= `SBSW_ERR_NONE;
      stored_reg <= 1'b0;
      rx_reg <= 8'h00;
      exec_reg <= 1'b0;
    end else begin
      if (pseq && seq_start) begin
        rep_reg <= 8'h00;
      end else if (pseq && repeat_inc) begin
        rep_reg <= rep_reg + 8'h01; // see RULE2
      end
      // codes above 5 are not defined; they are folded to the grammar code
      if (err_valid) begin
        err_reg <= (err_code > `SBSW_ERR_INIT) ? `SBSW_ERR_GRAMMAR : err_code; // see RULE4
        stored_reg <= 1'b1; // see RULE5
      end
      if (pseq && case_valid) begin
        rx_reg <= {step_num, case_num}; // see RULE6
      end
      if (mode == `SBSW_MODE_NOPROT || pseq) begin
        if (seq_start) begin
          exec_reg <= 1'b1; // see RULE9
        end else if (seq_done) begin
          exec_reg <= 1'b0;
        end
      end else begin
        exec_reg <= 1'b0;
      end
    end
  end
endmodule // sbsw_port

// ---- src/sbsw_regs.vh ----
// register offsets, field positions, mode codes and timing counts for the status word bank
`ifndef SBSW_REGS_VH
`define SBSW_REGS_VH
`define SBSW_IDX_P1_CNT 8'hCA
`define SBSW_IDX_P2_CNT 8'hCB
`define SBSW_IDX_TRACE 8'hCC
`define SBSW_IDX_P1_RX 8'hCD
`define SBSW_IDX_P2_RX 8'hCE
`define SBSW_IDX_CTRL 8'hCF
`define SBSW_IDX_MODE 8'hD0
`define SBSW_IDX_IRQ_STAT 8'hD1
`define SBSW_IDX_IRQ_MASK 8'hD2
`define SBSW_MODE_NOPROT 2'h0
`define SBSW_MODE_PSEQ 2'h1
`define SBSW_MODE_POLL 2'h2
`define SBSW_MODE_OTHER 2'h3
`define SBSW_ERR_NONE 4'h0
`define SBSW_ERR_NOFUNC 4'h1
`define SBSW_ERR_SEQNUM 4'h2
`define SBSW_ERR_OVFL 4'h3
`define SBSW_ERR_GRAMMAR 4'h4
`define SBSW_ERR_INIT 4'h5
`define SBSW_CTRL_RESTART 0
`define SBSW_CTRL_CTRACE 2
`define SBSW_CTRL_STRACE 4
`define SBSW_CTRL_ECHO 6
`define SBSW_CTRL_P1_EXEC 8
`define SBSW_CTRL_P1_STEPERR 9
`define SBSW_CTRL_P1_SEQEND 10
`define SBSW_CTRL_P1_ABORT 11
`define SBSW_CTRL_P2_EXEC 12
`define SBSW_CTRL_P2_STEPERR 13
`define SBSW_CTRL_P2_SEQEND 14
`define SBSW_CTRL_P2_ABORT 15
`define SBSW_CTRL_WMASK 16'h88FF
`define SBSW_RX_STORED 15
`define SBSW_RESTART_NS 1000
`define SBSW_CLK_NS 100
`define SBSW_RESTART_CYC ((`SBSW_RESTART_NS + `SBSW_CLK_NS - 1) / `SBSW_CLK_NS)
`define SBSW_IRQ_W 6
`endif

// ---- test/sbsw_bank_properties.sv ----
// assertion checker for the status word bank apb slave
`timescale 1ns/10ps
module sbsw_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [1:0] abort_done,
  input wire [1:0] comm_err_valid,
  input wire [2:0] p1_comm_code,
  input wire [1:0] port_restart,
  input wire [1:0] echo_disable,
  input wire [1:0] abort_req,
  input wire [3:0] p1_comm_err
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pwrite && paddr[11:2] == 10'h0CF;
  endsequence
  property p_setup_ready;
    s_setup |=> pready;
  endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
  property p_unmapped;
    psel && !penable && paddr[11:2] > 10'h0D2 |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_rd_upper;
    pready |-> prdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read half not zero");
  property p_echo_off;
    s_ctrl_wr ##0 !pwdata[6] |-> ##[1:3] !echo_disable[0];
  endproperty
  a_echo_off: assert property (p_echo_off) else $error("echo disable stuck");
  property p_restart_go;
    s_ctrl_wr ##0 pwdata[0] |-> ##[1:3] port_restart[0];
  endproperty
  a_restart_go: assert property (p_restart_go) else $error("restart not started");
  // restart must last long enough for the port to settle, then drop by itself
  property p_restart_hold;
    $rose(port_restart[1]) |-> port_restart[1] [*8] ##[1:4] !port_restart[1];
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("restart length wrong");
  property p_comm_err;
    comm_err_valid[0] && !port_restart[0] |=> p1_comm_err == {1'b0, $past(p1_comm_code)};
  endproperty
  a_comm_err: assert property (p_comm_err) else $error("comm error code not latched");
  property p_abort_clr;
    abort_done[0] && !psel |=> ##1 !abort_req[0];
  endproperty
  a_abort_clr: assert property (p_abort_clr) else $error("abort request not cleared");
endmodule // sbsw_props
bind sbsw_bank sbsw_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .abort_done(abort_done), .comm_err_valid(comm_err_valid),
  .p1_comm_code(p1_comm_code), .port_restart(port_restart), .echo_disable(echo_disable),
  .abort_req(abort_req), .p1_comm_err(p1_comm_err));

// ---- test/sbsw_tb.sv ----
// self-checking bench for the status word bank
`timescale 1ns/10ps
`include "sbsw_regs.vh"
module testbench;
  reg pclk, presetn, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  reg [7:0] p1_terminal_active, p2_terminal_active;
  reg [1:0] rx_byte, seq_start, seq_done, repeat_inc, err_valid, case_valid, trace_active;
  reg [1:0] step_error, seq_end, abort_done, comm_err_valid;
  reg [3:0] p1_err_code, p2_err_code, p1_case_num, p2_case_num, p1_step_num, p2_step_num;
  reg [2:0] p1_comm_code, p2_comm_code;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [1:0] port_restart, cont_trace_req, shot_trace_req, echo_disable, abort_req;
  wire [3:0] p1_comm_err, p2_comm_err;
  int num_errors = 0;
  int compares = 0;
  sbsw_bank dut (.*);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // holds the request until pready is seen; one idle cycle keeps drivers apart
  task automatic apb(input logic w, input logic [7:0] i, input logic [15:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, i, d, q, e);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [15:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, i, 16'h0000, q, e);
    chk(q, {16'h0000, x});
  endtask
  task automatic t_bcd;
    rdc(`SBSW_IDX_CTRL, 16'h0000);
    seq_start <= 2'b01;
    rx_byte <= 2'b11;
    cyc(3);
    seq_start <= 2'b00;
    rx_byte <= 2'b01;
    cyc(9);
    rx_byte <= 2'b00;
    cyc(1);
    rdc(`SBSW_IDX_P1_CNT, 16'h0012);
    rdc(`SBSW_IDX_P2_CNT, 16'h0003);
    rdc(`SBSW_IDX_CTRL, 16'h0100);
    seq_done <= 2'b01;
    cyc(1);
    seq_done <= 2'b00;
    cyc(1);
    rdc(`SBSW_IDX_CTRL, 16'h0000);
  endtask
  task automatic t_seq;
    wr(`SBSW_IDX_MODE, 16'h0001);
    repeat_inc <= 2'b10;
    cyc(255);
    repeat_inc <= 2'b00;
    cyc(1);
    rdc(`SBSW_IDX_P2_CNT, 16'h00FF);
    rdc(`SBSW_IDX_P1_CNT, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      p1_err_code <= i[3:0];
      err_valid <= 2'b01;
      cyc(1);
      err_valid <= 2'b00;
      cyc(1);
      rdc(`SBSW_IDX_TRACE, {4'h0, i[3:0], 8'h00});
    end
    p2_err_code <= 4'h7;
    p1_case_num <= 4'h5;
    p1_step_num <= 4'h9;
    err_valid <= 2'b10;
    case_valid <= 2'b01;
    cyc(1);
    err_valid <= 2'b00;
    case_valid <= 2'b00;
    cyc(1);
    rdc(`SBSW_IDX_TRACE, 16'h4500);
    rdc(`SBSW_IDX_P1_RX, 16'h8095);
    rdc(`SBSW_IDX_P2_RX, 16'h8000);
  endtask
  task automatic t_ctrl;
    wr(`SBSW_IDX_CTRL, 16'h00C3);
    cyc(2);
    chk({30'h0, port_restart}, 32'h3);
    chk({30'h0, echo_disable}, 32'h3);
    cyc(12);
    chk({30'h0, port_restart}, 32'h0);
    trace_active <= 2'b01;
    rdc(`SBSW_IDX_TRACE, 16'h00C1);
    trace_active <= 2'b00;
    rdc(`SBSW_IDX_P1_RX, 16'h0000);
    rdc(`SBSW_IDX_P2_CNT, 16'h0000);
    rdc(`SBSW_IDX_CTRL, 16'h00C0);
    wr(`SBSW_IDX_CTRL, 16'h08E4);
    cyc(2);
    chk({30'h0, abort_req}, 32'h1);
    chk({30'h0, cont_trace_req}, 32'h1);
    chk({30'h0, shot_trace_req}, 32'h2);
    abort_done <= 2'b01;
    cyc(1);
    abort_done <= 2'b00;
    cyc(2);
    chk({30'h0, abort_req}, 32'h0);
    wr(`SBSW_IDX_CTRL, 16'h0000);
    cyc(2);
    chk({30'h0, echo_disable}, 32'h0);
    chk({28'h0, cont_trace_req, shot_trace_req}, 32'h0);
    rdc(`SBSW_IDX_TRACE, 16'h0000);
  endtask
  task automatic t_poll;
    wr(`SBSW_IDX_MODE, 16'h0002);
    p1_terminal_active <= 8'hA5;
    p2_terminal_active <= 8'h5A;
    cyc(1);
    rdc(`SBSW_IDX_P1_CNT, 16'h00A5);
    rdc(`SBSW_IDX_P2_CNT, 16'h005A);
  endtask
  task automatic t_comm;
    for (int i = 0; i < 8; i++) begin
      p1_comm_code <= i[2:0];
      p2_comm_code <= ~i[2:0];
      comm_err_valid <= 2'b11;
      cyc(1);
      comm_err_valid <= 2'b00;
      cyc(2);
      chk({28'h0, p1_comm_err}, {29'h0, i[2:0]});
      chk({28'h0, p2_comm_err}, {29'h0, ~i[2:0]});
    end
  endtask
  // masked events must stay pending without raising the line
  task automatic t_irq;
    logic [31:0] q;
    logic e;
    wr(`SBSW_IDX_IRQ_STAT, 16'h003F);
    wr(`SBSW_IDX_IRQ_MASK, 16'h0000);
    seq_end <= 2'b01;
    step_error <= 2'b10;
    cyc(1);
    seq_end <= 2'b00;
    step_error <= 2'b00;
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rdc(`SBSW_IDX_IRQ_STAT, 16'h0009);
    wr(`SBSW_IDX_IRQ_MASK, 16'h0001);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(`SBSW_IDX_IRQ_STAT, 16'h0001);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rdc(`SBSW_IDX_IRQ_STAT, 16'h0008);
    apb(1'b0, 8'hFF, 16'h0000, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {p1_terminal_active, p2_terminal_active, rx_byte, seq_start, seq_done, repeat_inc} = '0;
    {err_valid, case_valid, trace_active, step_error, seq_end, abort_done, comm_err_valid} = '0;
    {p1_err_code, p2_err_code, p1_case_num, p2_case_num, p1_step_num, p2_step_num} = '0;
    {p1_comm_code, p2_comm_code} = '0;
    cyc(10);
    presetn <= 1'b1;
    cyc(1);
    chk({25'h0, port_restart, echo_disable, abort_req, irq}, 32'h0);
    t_bcd;
    t_seq;
    t_ctrl;
    t_poll;
    t_comm;
    t_irq;
    wrap_up;
  end
  // run needs about 450 cycles; this limit only catches a hang
  initial begin
    cyc(20000);
    num_errors++;
    wrap_up;
  end
endmodule // testbench
